// ===== logic/uedr_regs.sv
// endpoint descriptor registers with avalon slave and buffer manager transaction answers
//
// Functional notes
// R1 - the second-buffer count of endpoints 1 to 3 is a 7-bit byte count of 0 to 64, larger codes undefined.
// R2 - bit 7 of that count is an empty flag: clear means a packet is ready, set means IN is answered with NAK.
// R3 - one 7-bit size field per input endpoint serves both buffers, with the same 0 to 64 encoding.
// R4 - bit 7 of the buffer size entry is reserved, read-only and reads zero.
// R5 - endpoint 0 has fixed buffers: input at FEF8, output at FEF0.
// R6 - the four endpoint 0 registers decode at FF80 to FF83 as input config, input count, output config, output count.
// R7 - endpoint 0 fields sit at the same bit positions as in the endpoint 1 to 3 entries.
// R8 - with the interrupt enable bit 2 set, a completed transaction raises an interrupt, otherwise none; only endpoint 0 transactions interrupt here.
// R9 - a stall bit 3 set by software makes the endpoint answer STALL and is cleared by the next SETUP; only endpoint 0 can be stalled here.
// R10 - bit 5 of the endpoint 0 config is read-only and shows the DATA0/DATA1 toggle.
// R11 - the buffer manager serves an endpoint only while its enable bit 7 is set.
// R12 - the endpoint 0 input count is 4 bits of 0 to 8 bytes, codes 9 to 15 act as 8.
// R13 - after reset the endpoint 0 input count is zero with its empty flag set.
// R14 - with double buffering on, the toggle bit picks X or Y buffer, otherwise only X is used.
// R15 - when the host acknowledges IN data, the buffer's empty flag is set and the toggle inverted.
//
// Local design decision: register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
module uedr_regs
  import uedr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [15:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [7:0] avs_writedata,
  output logic [7:0] avs_readdata,
  output logic avs_waitrequest,
  input wire uedr_tok_t tok,
  output uedr_reply_t reply,
  output logic irqPulse
);
  logic waitReq_reg;
  logic [7:0] readData_reg;
  logic [7:0] readData_next;
  uedr_reply_t reply_reg;
  uedr_reply_t reply_next;
  logic irq_reg;
  logic irq_next;
  logic [7:0] outCfg_reg;
  logic [7:0] outCount_reg;

  logic busTake;
  logic busWr;
  logic in0CfgHit;
  logic in0CountHit;
  logic outCfgHit;
  logic outCountHit;
  logic [NUM_EP-1:0] cfgHit;
  logic [NUM_EP-1:0] countHit;
  logic [NUM_EP-1:0] sizeHit;

  logic [7:0] in0Cfg;
  logic [7:0] in0Count;
  logic [3:0] in0Len;
  logic [7:0] slotCfg [NUM_EP];
  logic [7:0] slotCount [NUM_EP];
  logic [7:0] slotSize [NUM_EP];
  logic [NUM_EP-1:0] slotUseY;
  logic [NUM_EP-1:0] slotAck;

  logic ep0Sel;
  logic in0Ack;
  logic outAccept;

  assign avs_readdata = readData_reg;
  assign avs_waitrequest = waitReq_reg;
  assign reply = reply_reg;
  assign irqPulse = irq_reg;

  // requests are sampled while waitrequest is high, answered one cycle later
  assign busTake = (avs_read | avs_write) & waitReq_reg;
  assign busWr = avs_write & ~waitReq_reg;

  assign in0CfgHit = avs_address == IN_EP0_CONFIG_ADDR; // R6
  assign in0CountHit = avs_address == IN_EP0_COUNT_ADDR; // R6
  assign outCfgHit = avs_address == OUT_EP0_CONFIG_ADDR; // R6
  assign outCountHit = avs_address == OUT_EP0_COUNT_ADDR; // R6

  assign ep0Sel = tok.ep == 2'h0;
  assign in0Ack = tok.ack & ep0Sel;
  assign outAccept = tok.outTok & ep0Sel & outCfg_reg[MGR_EN_BIT] & ~outCfg_reg[STALL_BIT]
                     & ~outCount_reg[EMPTY_BIT];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      waitReq_reg <= 1'b1;
    end else begin
      waitReq_reg <= ~busTake;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      readData_reg <= 8'h00;
    end else if (busTake) begin
      readData_reg <= readData_next;
    end
  end

  uedr_ep0_in u_ep0_in (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .wrCfg(busWr & in0CfgHit),
    .wrCount(busWr & in0CountHit),
    .wrData(avs_writedata),
    .setup(tok.setupTok & ep0Sel),
    .ack(in0Ack),
    .cfgView(in0Cfg),
    .countView(in0Count),
    .effLen(in0Len)
  );

  genvar gi;
  generate
    for (gi = 0; gi < NUM_EP; gi++) begin : g_slot
      assign cfgHit[gi] = avs_address == IN_EP_CONFIG_BASE + 16'(gi + 1);
      assign countHit[gi] = avs_address == IN_EP_SECOND_BUFFER_COUNT_BASE + 16'(gi + 1);
      assign sizeHit[gi] = avs_address == IN_EP_BUFFER_SIZE_BASE + 16'(gi + 1);
      assign slotAck[gi] = tok.ack & (tok.ep == 2'(gi + 1));
      uedr_ep_slot u_slot (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .wrCfg(busWr & cfgHit[gi]),
        .wrCount(busWr & countHit[gi]),
        .wrSize(busWr & sizeHit[gi]),
        .wrData(avs_writedata),
        .ack(slotAck[gi]),
        .cfgView(slotCfg[gi]),
        .countView(slotCount[gi]),
        .sizeView(slotSize[gi]),
        .useY(slotUseY[gi])
      );
    end
  endgenerate

  // read mux, unmapped addresses read zero
  always_comb begin
    readData_next = 8'h00;
    if (in0CfgHit) begin
      readData_next = in0Cfg;
    end
    if (in0CountHit) begin
      readData_next = in0Count;
    end
    if (outCfgHit) begin
      readData_next = outCfg_reg;
    end
    if (outCountHit) begin
      readData_next = outCount_reg;
    end
    for (int i = 0; i < NUM_EP; i++) begin
      if (cfgHit[i]) begin
        readData_next = slotCfg[i];
      end
      if (countHit[i]) begin
        readData_next = slotCount[i];
      end
      if (sizeHit[i]) begin
        readData_next = slotSize[i];
      end
    end
  end

  // output endpoint 0 configuration
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      outCfg_reg <= EP0_CONFIG_RST;
    end else begin
      if (tok.setupTok && ep0Sel) begin
        outCfg_reg[STALL_BIT] <= 1'b0; // R9
      end
      if (busWr && outCfgHit) begin
        outCfg_reg <= (avs_writedata & EP0_CONFIG_WMASK) | (outCfg_reg & ~EP0_CONFIG_WMASK);
      end
      if (outAccept) begin
        outCfg_reg[SEQ_BIT] <= ~outCfg_reg[SEQ_BIT]; // R10
      end
    end
  end

  // output endpoint 0 count: flag set means a host packet waits in the buffer
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      outCount_reg <= EP0_COUNT_RST;
    end else begin
      if (busWr && outCountHit) begin
        outCount_reg <= avs_writedata & EP0_COUNT_WMASK;
      end
      if (outAccept) begin
        outCount_reg <= {1'b1, 3'h0, tok.outLen};
      end
    end
  end

  // answer to host tokens
  always_comb begin
    reply_next = '0;
    reply_next.kind = RPL_NONE;
    reply_next.ep = tok.ep;
    if (tok.inTok) begin
      reply_next.valid = 1'b1;
      if (ep0Sel) begin
        reply_next.dataPid = in0Cfg[SEQ_BIT];
        if (!in0Cfg[MGR_EN_BIT]) begin
          reply_next.kind = RPL_NONE; // R11
        end else if (in0Cfg[STALL_BIT]) begin
          reply_next.kind = RPL_STALL; // R9
        end else if (in0Count[EMPTY_BIT]) begin
          reply_next.kind = RPL_NAK; // R2
        end else begin
          reply_next.kind = RPL_DATA;
          reply_next.len = {3'h0, in0Len}; // R12
          reply_next.addr = IN_EP0_BUF_ADDR; // R5
        end
      end else begin
        reply_next.dataPid = slotCfg[tok.ep - 2'h1][SEQ_BIT];
        reply_next.useY = slotUseY[tok.ep - 2'h1];
        if (!slotCfg[tok.ep - 2'h1][MGR_EN_BIT]) begin
          reply_next.kind = RPL_NONE; // R11
        end else if (!slotUseY[tok.ep - 2'h1]) begin
          reply_next.kind = RPL_XBUF; // R14
        end else if (slotCount[tok.ep - 2'h1][EMPTY_BIT]) begin
          reply_next.kind = RPL_NAK; // R2
        end else begin
          reply_next.kind = RPL_DATA;
          reply_next.len = slotCount[tok.ep - 2'h1][6:0]; // R1
        end
      end
    end else if (tok.outTok && ep0Sel) begin
      reply_next.valid = 1'b1;
      reply_next.dataPid = outCfg_reg[SEQ_BIT];
      if (!outCfg_reg[MGR_EN_BIT]) begin
        reply_next.kind = RPL_NONE; // R11
      end else if (outCfg_reg[STALL_BIT]) begin
        reply_next.kind = RPL_STALL; // R9
      end else if (outCount_reg[EMPTY_BIT]) begin
        reply_next.kind = RPL_NAK;
      end else begin
        reply_next.kind = RPL_DATA;
        reply_next.len = {3'h0, tok.outLen};
        reply_next.addr = OUT_EP0_BUF_ADDR; // R5
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      reply_reg <= '0;
    end else begin
      reply_reg <= reply_next;
    end
  end

  assign irq_next = (in0Ack & in0Cfg[IRQ_EN_BIT]) | (outAccept & outCfg_reg[IRQ_EN_BIT]); // R8

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  busAnswer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not a single cycle");

  ep0Decode_a: assert property (avs_read && avs_waitrequest && avs_address == IN_EP0_COUNT_ADDR // R6
    |=> avs_readdata == $past(in0Count))
    else $error("input count read wrong");

  sizeRsv_a: assert property (avs_read && avs_waitrequest && avs_address == IN_EP_BUFFER_SIZE_BASE + 16'h1 // R4
    |=> !avs_readdata[7])
    else $error("size reserved bit not zero");

  mgrGate_a: assert property (tok.inTok && ep0Sel && !in0Cfg[MGR_EN_BIT] |=> reply.kind == RPL_NONE) // R11
    else $error("disabled endpoint served");

  stallAns_a: assert property (tok.inTok && ep0Sel && in0Cfg[MGR_EN_BIT] && in0Cfg[STALL_BIT] // R9
    |=> reply.valid && reply.kind == RPL_STALL)
    else $error("stall not answered");

  stallClear_a: assert property (tok.setupTok && ep0Sel && !(busWr && in0CfgHit) |=> !in0Cfg[STALL_BIT]) // R9
    else $error("stall not cleared by setup");

  emptyNak_a: assert property (tok.inTok && ep0Sel && in0Cfg[MGR_EN_BIT] && !in0Cfg[STALL_BIT] // R2
    && in0Count[EMPTY_BIT] |=> reply.kind == RPL_NAK)
    else $error("empty buffer not answered with nak");

  lenClamp_a: assert property (reply.valid && reply.kind == RPL_DATA && reply.ep == 2'h0 // R12
    |-> reply.len <= 7'(MAX_EP0_COUNT))
    else $error("endpoint 0 length above eight");

  fixedAddr_a: assert property (tok.inTok && ep0Sel && in0Cfg[MGR_EN_BIT] && !in0Cfg[STALL_BIT] // R5
    && !in0Count[EMPTY_BIT] |=> reply.addr == IN_EP0_BUF_ADDR && reply.kind == RPL_DATA)
    else $error("input buffer address wrong");

  irqEnable_a: assert property (in0Ack && !tok.outTok |=> irqPulse == $past(in0Cfg[IRQ_EN_BIT])) // R8
    else $error("interrupt does not follow enable");

  ackToggle_a: assert property (in0Ack && !(busWr && in0CfgHit) // R15
    |=> in0Cfg[SEQ_BIT] != $past(in0Cfg[SEQ_BIT]) && in0Count[EMPTY_BIT])
    else $error("ack did not invert toggle and set empty");

  xOnly_a: assert property (tok.inTok && !ep0Sel && !slotCfg[tok.ep - 2'h1][DOUBLE_BUF_BIT] // R14
    && slotCfg[tok.ep - 2'h1][MGR_EN_BIT] |=> reply.kind == RPL_XBUF && !reply.useY)
    else $error("second buffer used without double buffering");

  yPick_a: assert property (tok.inTok && !ep0Sel && slotCfg[tok.ep - 2'h1][DOUBLE_BUF_BIT] // R14
    && slotCfg[tok.ep - 2'h1][MGR_EN_BIT] |=> reply.useY == $past(slotCfg[tok.ep - 2'h1][SEQ_BIT]))
    else $error("toggle does not pick the buffer");

  yCount_a: assert property (tok.inTok && !ep0Sel && slotUseY[tok.ep - 2'h1] // R1
    && slotCfg[tok.ep - 2'h1][MGR_EN_BIT] && !slotCount[tok.ep - 2'h1][EMPTY_BIT]
    |=> reply.kind == RPL_DATA && reply.len == $past(slotCount[tok.ep - 2'h1][6:0]))
    else $error("second buffer count not answered");

  ackY_a: assert property (tok.ack && !ep0Sel && slotUseY[tok.ep - 2'h1] // R15
    |=> slotCount[$past(tok.ep) - 2'h1][EMPTY_BIT]
    && slotCfg[$past(tok.ep) - 2'h1][SEQ_BIT] != $past(slotCfg[tok.ep - 2'h1][SEQ_BIT]))
    else $error("second buffer ack not applied");

  outData_a: assert property (tok.outTok && ep0Sel && outCfg_reg[MGR_EN_BIT] && !outCfg_reg[STALL_BIT] // R5
    && !outCount_reg[EMPTY_BIT] |=> reply.kind == RPL_DATA && reply.addr == OUT_EP0_BUF_ADDR
    && outCount_reg[EMPTY_BIT] && outCount_reg[3:0] == $past(tok.outLen))
    else $error("accepted out data not stored");

  outStall_a: assert property (tok.outTok && ep0Sel && outCfg_reg[MGR_EN_BIT] && outCfg_reg[STALL_BIT] // R9
    |=> reply.valid && reply.kind == RPL_STALL)
    else $error("out stall not answered");

  outIrq_a: assert property (outAccept && !in0Ack |=> irqPulse == $past(outCfg_reg[IRQ_EN_BIT])) // R8
    else $error("out interrupt does not follow enable");

  irqQuiet_a: assert property (!in0Ack && !outAccept |=> !irqPulse) // R8
    else $error("interrupt without completion");

endmodule : uedr_regs
`default_nettype wire

// ===== logic/uedr_pkg.sv
// package: register map, field positions, reset values and carrier types of the endpoint descriptor logic
package uedr_pkg;

  localparam logic [15:0] IN_EP0_CONFIG_ADDR = 16'hff80;
  localparam logic [15:0] IN_EP0_COUNT_ADDR = 16'hff81;
  localparam logic [15:0] OUT_EP0_CONFIG_ADDR = 16'hff82;
  localparam logic [15:0] OUT_EP0_COUNT_ADDR = 16'hff83;
  // endpoints 1 to 3 sit at base + endpoint number
  localparam logic [15:0] IN_EP_CONFIG_BASE = 16'hff90;
  localparam logic [15:0] IN_EP_SECOND_BUFFER_COUNT_BASE = 16'hff94;
  localparam logic [15:0] IN_EP_BUFFER_SIZE_BASE = 16'hff98;

  localparam logic [15:0] IN_EP0_BUF_ADDR = 16'hfef8;
  localparam logic [15:0] OUT_EP0_BUF_ADDR = 16'hfef0;

  localparam int MGR_EN_BIT = 7;
  localparam int SEQ_BIT = 5;
  localparam int DOUBLE_BUF_BIT = 4;
  localparam int STALL_BIT = 3;
  localparam int IRQ_EN_BIT = 2;
  localparam int EMPTY_BIT = 7;

  localparam logic [6:0] MAX_EP_COUNT = 7'h40;
  localparam logic [3:0] MAX_EP0_COUNT = 4'h8;

  localparam logic [7:0] EP0_CONFIG_RST = 8'h00;
  localparam logic [7:0] EP0_COUNT_RST = 8'h80;
  localparam logic [7:0] EP_CONFIG_RST = 8'h00;
  localparam logic [7:0] EP_COUNT_RST = 8'h80;
  localparam logic [6:0] EP_SIZE_RST = 7'h00;

  localparam logic [7:0] EP0_CONFIG_WMASK = 8'h8c;
  localparam logic [7:0] EP_CONFIG_WMASK = 8'h90;
  localparam logic [7:0] EP0_COUNT_WMASK = 8'h8f;

  localparam int NUM_EP = 3;

  typedef enum logic [2:0] {
    RPL_NONE,
    RPL_NAK,
    RPL_STALL,
    RPL_DATA,
    RPL_XBUF
  } uedr_kind_t;

  typedef struct packed {
    logic inTok;
    logic outTok;
    logic setupTok;
    logic ack;
    logic [1:0] ep;
    logic [3:0] outLen;
  } uedr_tok_t;

  typedef struct packed {
    logic valid;
    uedr_kind_t kind;
    logic [1:0] ep;
    logic useY;
    logic dataPid;
    logic [6:0] len;
    logic [15:0] addr;
  } uedr_reply_t;

endpackage : uedr_pkg

// ===== logic/uedr_ep_slot.sv
// one input endpoint 1 to 3: own config bits, second-buffer count and shared buffer size
`timescale 1ns/1ps
`default_nettype none
module uedr_ep_slot
  import uedr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wrCfg,
  input wire logic wrCount,
  input wire logic wrSize,
  input wire logic [7:0] wrData,
  input wire logic ack,
  output logic [7:0] cfgView,
  output logic [7:0] countView,
  output logic [7:0] sizeView,
  output logic useY
);
  logic [7:0] cfg_reg;
  logic [7:0] count_reg;
  logic [6:0] size_reg;

  assign useY = cfg_reg[DOUBLE_BUF_BIT] & cfg_reg[SEQ_BIT]; // R14
  assign cfgView = cfg_reg;
  assign countView = count_reg; // R1
  assign sizeView = {1'b0, size_reg}; // R3 R4

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_reg <= EP_CONFIG_RST;
    end else begin
      if (wrCfg) begin
        cfg_reg <= (wrData & EP_CONFIG_WMASK) | (cfg_reg & ~EP_CONFIG_WMASK);
      end
      if (ack) begin
        cfg_reg[SEQ_BIT] <= ~cfg_reg[SEQ_BIT]; // R15
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_reg <= EP_COUNT_RST;
    end else begin
      if (wrCount) begin
        count_reg <= wrData;
      end
      if (ack && useY) begin
        count_reg[EMPTY_BIT] <= 1'b1; // R15 R2
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      size_reg <= EP_SIZE_RST;
    end else if (wrSize) begin
      size_reg <= wrData[6:0];
    end
  end

endmodule : uedr_ep_slot
`default_nettype wire

// ===== logic/uedr_ep0_in.sv
// input endpoint 0: configuration and byte count registers
`timescale 1ns/1ps
`default_nettype none
module uedr_ep0_in
  import uedr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic wrCfg,
  input wire logic wrCount,
  input wire logic [7:0] wrData,
  input wire logic setup,
  input wire logic ack,
  output logic [7:0] cfgView,
  output logic [7:0] countView,
  output logic [3:0] effLen
);
  logic [7:0] cfg_reg;
  logic [7:0] count_reg;

  assign cfgView = cfg_reg; // R7
  assign countView = count_reg;
  assign effLen = count_reg[3] ? MAX_EP0_COUNT : count_reg[3:0]; // R12

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      cfg_reg <= EP0_CONFIG_RST;
    end else begin
      // a stall written in the setup cycle survives
      if (setup) begin
        cfg_reg[STALL_BIT] <= 1'b0; // R9
      end
      if (wrCfg) begin
        cfg_reg <= (wrData & EP0_CONFIG_WMASK) | (cfg_reg & ~EP0_CONFIG_WMASK); // R10
      end
      if (ack) begin
        cfg_reg[SEQ_BIT] <= ~cfg_reg[SEQ_BIT]; // R15 R10
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_reg <= EP0_COUNT_RST; // R13
    end else begin
      if (wrCount) begin
        count_reg <= wrData & EP0_COUNT_WMASK;
      end
      if (ack) begin
        count_reg[EMPTY_BIT] <= 1'b1; // R15
      end
    end
  end

endmodule : uedr_ep0_in
`default_nettype wire

// ===== tb/uedr_host_model.sv
// host side model: issues IN, OUT and SETUP tokens and acknowledges every data packet it receives
`timescale 1ns/1ps
`default_nettype none
module uedr_host_model
  import uedr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic doIn,
  input wire logic doSetup,
  input wire logic doOut,
  input wire logic [3:0] doLen,
  input wire logic [1:0] doEp,
  input wire uedr_reply_t reply,
  output uedr_tok_t tok
);
  // the answer to OUT data is the device's handshake, the host does not acknowledge it
  logic outWait;

  // every flag is a one-cycle pulse; an ack always follows a data answer to IN at once
  always_ff @(posedge clk_sys) begin
    tok <= '0;
    outWait <= tok.outTok;
    if (!sys_rst) begin
      if (reply.valid && !outWait && (reply.kind == RPL_DATA || reply.kind == RPL_XBUF)) begin
        tok.ack <= 1'b1;
        tok.ep <= reply.ep;
      end else if (doIn) begin
        tok.inTok <= 1'b1;
        tok.ep <= doEp;
      end else if (doOut) begin
        tok.outTok <= 1'b1;
        tok.outLen <= doLen;
      end else if (doSetup) begin
        tok.setupTok <= 1'b1;
      end
    end
  end

endmodule : uedr_host_model
`default_nettype wire

// ===== tb/usb_endpoint_descriptor_regs_bench.sv
// bench: register map and token answers of the descriptor logic against a behavioural model
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module usb_endpoint_descriptor_regs_bench
  import uedr_pkg::*;
;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] avs_address = 16'h0000;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [7:0] avs_writedata = 8'h00;
  logic [7:0] avs_readdata;
  logic avs_waitrequest;
  logic doIn = 1'b0;
  logic doSetup = 1'b0;
  logic doOut = 1'b0;
  logic [3:0] doLen = 4'h0;
  logic [1:0] doEp = 2'h0;
  uedr_tok_t tok;
  uedr_reply_t reply;
  logic irqPulse;
  int n_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [7:0] mdl [0:31];
  logic [7:0] rnd = 8'h2b;
  logic [7:0] q;

  always #4 clk_sys = ~clk_sys;

  uedr_regs uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .tok(tok), .reply(reply), .irqPulse(irqPulse));

  uedr_host_model host (.clk_sys(clk_sys), .sys_rst(sys_rst), .doIn(doIn), .doSetup(doSetup), .doOut(doOut),
    .doLen(doLen), .doEp(doEp), .reply(reply), .tok(tok));

  task automatic stop_test;
    if (n_errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      stop_test();
    end
  end

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr

  // software-writable bits per register offset, zero for unmapped places
  function automatic logic [7:0] wmask(input logic [4:0] i);
    case (i)
      5'd0, 5'd2: return 8'h8c;
      5'd1, 5'd3: return 8'h8f;
      5'd17, 5'd18, 5'd19: return 8'h90;
      5'd21, 5'd22, 5'd23: return 8'hff;
      5'd25, 5'd26, 5'd27: return 8'h7f;
      default: return 8'h00;
    endcase
  endfunction : wmask

  task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (wr) mdl[a[4:0]] = (mdl[a[4:0]] & ~wmask(a[4:0])) | (d & wmask(a[4:0]));
    // one idle edge so the next request never reassigns a strobe in the release step
    @(posedge clk_sys);
  endtask : bus

  task automatic rd(input logic [15:0] a);
    bus(1'b0, a, 8'h00);
    `CHK(q, mdl[a[4:0]])
  endtask : rd

  task automatic tx(input logic [1:0] ep);
    logic [7:0] c;
    logic [7:0] n;
    logic y;
    uedr_kind_t k;
    int w;
    c = mdl[ep == 2'd0 ? 0 : 16 + ep];
    n = mdl[ep == 2'd0 ? 1 : 20 + ep];
    y = ep != 2'd0 && c[4] && c[5];
    if (!c[7]) k = RPL_NONE;
    else if (ep == 2'd0 && c[3]) k = RPL_STALL;
    else if (ep != 2'd0 && !y) k = RPL_XBUF;
    else if (n[7]) k = RPL_NAK;
    else k = RPL_DATA;
    doIn <= 1'b1;
    doEp <= ep;
    @(posedge clk_sys);
    doIn <= 1'b0;
    w = 0;
    while (reply.valid !== 1'b1 && w < 10) begin
      @(posedge clk_sys);
      w++;
    end
    `CHK(reply.valid, 1'b1)
    `CHK(reply.kind, k)
    `CHK(reply.dataPid, c[5])
    `CHK(reply.useY, y)
    `CHK(reply.ep, ep)
    if (k == RPL_DATA) begin
      `CHK(reply.len, ep == 2'd0 ? (n[3:0] > 4'h8 ? 7'h08 : {3'h0, n[3:0]}) : n[6:0])
      `CHK(reply.addr, ep == 2'd0 ? 16'hfef8 : 16'h0000)
    end
    if (k == RPL_DATA || k == RPL_XBUF) begin
      @(posedge clk_sys);
      @(posedge clk_sys);
      `CHK(irqPulse, ep == 2'd0 && c[2])
      mdl[ep == 2'd0 ? 0 : 16 + ep] ^= 8'h20;
      if (ep == 2'd0 || y) mdl[ep == 2'd0 ? 1 : 20 + ep] |= 8'h80;
    end
  endtask : tx

  // host OUT data to endpoint 0: answer, interrupt and stored length
  task automatic ox(input logic [3:0] l);
    logic [7:0] c;
    uedr_kind_t k;
    c = mdl[2];
    if (!c[7]) k = RPL_NONE;
    else if (c[3]) k = RPL_STALL;
    else if (mdl[3][7]) k = RPL_NAK;
    else k = RPL_DATA;
    doOut <= 1'b1;
    doLen <= l;
    @(posedge clk_sys);
    doOut <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK(reply.valid, 1'b1)
    `CHK(reply.kind, k)
    `CHK(reply.dataPid, c[5])
    `CHK(irqPulse, k == RPL_DATA && c[2])
    if (k == RPL_DATA) begin
      `CHK(reply.len, 7'(l))
      `CHK(reply.addr, 16'hfef0)
      mdl[2] ^= 8'h20;
      mdl[3] = {4'h8, l};
    end
  endtask : ox

  initial begin
    for (int i = 0; i < 32; i++) mdl[i] = (i == 1 || i == 3 || (i > 20 && i < 24)) ? 8'h80 : 8'h00;
    repeat (20) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    for (int i = 0; i < 32; i++) rd(16'(16'hff80 + i));
    for (int i = 0; i < 32; i++) begin
      rnd = lfsr(rnd);
      bus(1'b1, 16'(16'hff80 + i), rnd);
      rd(16'(16'hff80 + i));
    end
    bus(1'b1, 16'hff80, 8'h84);
    bus(1'b1, 16'hff81, 8'h09);
    tx(2'd0);
    rd(16'hff80);
    rd(16'hff81);
    bus(1'b1, 16'hff81, 8'h03);
    bus(1'b1, 16'hff80, 8'h80);
    tx(2'd0);
    tx(2'd0);
    bus(1'b1, 16'hff80, 8'h00);
    tx(2'd0);
    for (int n = 1; n < 4; n++) begin
      rnd = lfsr(rnd);
      bus(1'b1, 16'(16'hff90 + n), 8'h90);
      bus(1'b1, 16'(16'hff94 + n), n == 1 ? 8'h40 : rnd % 8'd65);
      tx(2'(n));
      tx(2'(n));
      tx(2'(n));
      tx(2'(n));
      rd(16'(16'hff94 + n));
    end
    bus(1'b1, 16'hff91, 8'h80);
    tx(2'd1);
    tx(2'd1);
    bus(1'b1, 16'hff82, 8'h84);
    bus(1'b1, 16'hff83, 8'h00);
    ox(4'h6);
    ox(4'h2);
    rd(16'hff82);
    rd(16'hff83);
    bus(1'b1, 16'hff81, 8'h05);
    bus(1'b1, 16'hff80, 8'h88);
    tx(2'd0);
    bus(1'b1, 16'hff82, 8'h88);
    ox(4'h1);
    doSetup <= 1'b1;
    @(posedge clk_sys);
    doSetup <= 1'b0;
    repeat (3) @(posedge clk_sys);
    mdl[0] &= 8'hf7;
    mdl[2] &= 8'hf7;
    rd(16'hff80);
    rd(16'hff82);
    tx(2'd0);
    stop_test();
  end

endmodule : usb_endpoint_descriptor_regs_bench
`default_nettype wire
